// *** hw/loop_wd_pkg.sv ***
// Constants shared by the loop watchdog / interval timer.
// Assumes clk is the main oscillator clock and the CPU register port is byte wide.
package loop_wd_pkg;
	// Clock rate of clk in MHz and its period in ns
	localparam int CLK_MHZ = 50;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	// Register addresses on the CPU data port
	localparam logic [15:0] CLOCK_SELECT_ADDR = 16'hFF42;
	localparam logic [15:0] MODE_RUN_ADDR = 16'hFFF9;
	// Values after reset
	localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
	localparam logic [7:0] MODE_RUN_RESET = 8'h00;
	// Implemented bits; the rest read as zero
	localparam logic [7:0] CLOCK_SELECT_MASK = 8'hF7;
	localparam logic [7:0] MODE_RUN_MASK = 8'h98;
	// Field positions
	localparam int RUN_BIT = 7;
	localparam int WD_MODE_BIT = 4;
	localparam int OVF_ACTION_BIT = 3;
	localparam int WD_CLK_SEL_LSB = 0;
	localparam int WD_CLK_SEL_WIDTH = 3;
	// Prescaler tap for code 0, tap for the longest code, and the code that jumps
	localparam int BASE_TAP = 3;
	localparam int LONG_TAP = 11;
	localparam logic [2:0] LONG_CODE = 3'h7;
	// Widths of the prescaler and the loop counter
	localparam int PRESCALE_BITS = 11;
	localparam int COUNT_BITS = 8;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	// What an overflow does
	typedef enum logic [1:0] {ACT_INTERVAL, ACT_NMI, ACT_RESET} ovf_action_t;
endpackage

// *** hw/loop_watchdog_interval_timer.sv ***
// Loop watchdog and interval timer with its two CPU registers.
// Assumes: clk is the main oscillator clock, all inputs synchronous to clk,
// the interrupt controller holds the pending flag and feeds it back.

// What this block does and what software must do
// R1: Mode select 0 gives maskable interrupt per overflow
// R2: Watchdog, action 0: overflow raises non-maskable request
// R3: Watchdog mode 2: overflow raises system reset
// R4: Both mode bits 1 select watchdog mode 2
// R5: Run write 1 clears counter, starts; 0 has no effect
// R6: Software cannot clear run once set
// R7: Software cannot clear mode bits once set
// R8: Interval timing starts immediately on run
// R9: Interval mode repeats interrupt every period
// R10: Reset clears mode/run register
// R11: Reset clears clock-select register
// R12: Periods 2^11..2^17, code 7 gives 2^19
// R13: Internal clock is main clock, halved when bit 0
// R14: Prescaler cleared only by reset, first period slightly short
// R15: Mode set with pending flag raises non-maskable
// R16: Software checks pending flag before watchdog mode
// R17: Software stops timer before clock-select change
// R18: Clock select byte writes only; mode bit ok
// R19: Counts in halt, stops in stop standby
// R20: Stops while CPU runs on subsystem clock
module loop_watchdog_interval_timer
	import loop_wd_pkg::*;
(
	input wire logic clk, // Main oscillator clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [15:0] addr, // CPU register address
	input wire logic wr_en, // Write strobe, one cycle
	input wire logic bit_wr, // Write is a single-bit manipulation
	input wire logic [2:0] bit_idx, // Bit addressed by a single-bit write
	input wire logic [7:0] wdata, // Write data; bit 0 is the value of a bit write
	input wire logic rd_en, // Read strobe, one cycle
	input wire logic osc_mode_bit, // 1: internal clock is the main clock, 0: half of it
	input wire logic halt_standby, // CPU in halt standby
	input wire logic stop_standby, // CPU in stop standby
	input wire logic sub_clock_active, // CPU clock taken from the subsystem clock
	input wire logic timer_irq_pending_flag, // Pending flag of the timer interrupt
	output logic [7:0] rdata, // Read data, valid the cycle after rd_en
	output logic maskable_irq_req, // Interval overflow request, one-cycle pulse
	output logic nmi_req, // Non-maskable request, one-cycle pulse
	output logic sys_reset_req // System reset request, one-cycle pulse
);
	import loop_wd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] clock_select; // Clock-select register
	logic run; // Counting enabled
	logic watchdog_mode_select; // Watchdog instead of interval timer
	logic overflow_action_select; // Reset instead of non-maskable
	logic [7:0] mode_run_view; // Mode/run register as read
	logic [7:0] next_mode_run; // Mode/run value the current write proposes
	logic clock_sel_wr; // Byte write to clock-select register
	logic mode_run_wr; // Any write to mode/run register
	logic run_kick; // Write that puts 1 into run
	logic late_wd_set; // Watchdog mode set while interrupt already pending
	logic int_clk_phase; // Toggles for the halved internal clock
	logic int_clk_en; // One pulse per internal clock period
	logic count_allow; // Counting is not frozen by standby or clock source
	logic [PRESCALE_BITS-1:0] prescale; // Free-running prescaler
	logic count_tick; // One pulse per count clock period
	logic [COUNT_BITS-1:0] count; // Loop counter
	logic overflow; // Counter wraps this cycle
	ovf_action_t action; // What an overflow causes now

	// Prescaler reaches the end of the selected tap's period
	function automatic logic tap_done(input logic [PRESCALE_BITS-1:0] ps, input logic [2:0] code);
		logic [PRESCALE_BITS-1:0] mask;
		int tap;
		tap = (code == LONG_CODE) ? LONG_TAP : BASE_TAP + int'(code);
		mask = PRESCALE_BITS'((1 << tap) - 1);
		return &(ps | ~mask);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register writes

	// Decode the two register writes
	assign clock_sel_wr = wr_en && !bit_wr && (addr == CLOCK_SELECT_ADDR); // see R18
	assign mode_run_wr = wr_en && (addr == MODE_RUN_ADDR);

	// Value a write to mode/run proposes: whole byte or one bit replaced
	always_comb begin
		next_mode_run = mode_run_view;
		if (bit_wr) begin
			next_mode_run[bit_idx] = wdata[0];
		end else begin
			next_mode_run = wdata;
		end
	end

	// Only a 1 actually written into run clears and starts the counter
	assign run_kick = mode_run_wr && next_mode_run[RUN_BIT]
		&& (!bit_wr || (bit_idx == 3'(RUN_BIT))); // see R5

	// Watchdog mode turned on while the timer request is pending
	assign late_wd_set = mode_run_wr && next_mode_run[WD_MODE_BIT] && !watchdog_mode_select
		&& timer_irq_pending_flag; // see R15

	// Clock-select register, byte writes only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clock_select <= CLOCK_SELECT_RESET; // see R11
		end else if (clock_sel_wr) begin
			clock_select <= wdata & CLOCK_SELECT_MASK;
		end
	end

	// Mode/run bits: set by software, cleared only by reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run <= MODE_RUN_RESET[RUN_BIT]; // see R10
			watchdog_mode_select <= MODE_RUN_RESET[WD_MODE_BIT];
			overflow_action_select <= MODE_RUN_RESET[OVF_ACTION_BIT];
		end else if (mode_run_wr) begin
			run <= run | next_mode_run[RUN_BIT]; // see R6
			watchdog_mode_select <= watchdog_mode_select | next_mode_run[WD_MODE_BIT]; // see R7
			overflow_action_select <= overflow_action_select
				| next_mode_run[OVF_ACTION_BIT]; // see R7
		end
	end

	// Assemble the readable view of mode/run
	always_comb begin
		mode_run_view = 8'h00;
		mode_run_view[RUN_BIT] = run;
		mode_run_view[WD_MODE_BIT] = watchdog_mode_select;
		mode_run_view[OVF_ACTION_BIT] = overflow_action_select;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			if (addr == CLOCK_SELECT_ADDR) begin
				rdata <= clock_select;
			end else if (addr == MODE_RUN_ADDR) begin
				rdata <= mode_run_view & MODE_RUN_MASK;
			end else begin
				rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Internal clock and prescaler

	// Halt keeps counting; stop standby and subsystem clock freeze it
	assign count_allow = !stop_standby && !sub_clock_active; // see R19 R20

	// Divide by two unless the oscillation mode bit selects full rate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_clk_phase <= 1'b0;
		end else begin
			int_clk_phase <= !int_clk_phase;
		end
	end
	assign int_clk_en = osc_mode_bit || int_clk_phase; // see R13

	// Prescaler is never cleared by a run write, so the first period may be short
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prescale <= '0;
		end else if (int_clk_en && count_allow) begin
			prescale <= prescale + 1'b1; // see R14
		end
	end

	// Count clock taken from the selected tap
	assign count_tick = int_clk_en && count_allow
		&& tap_done(prescale, clock_select[WD_CLK_SEL_LSB +: WD_CLK_SEL_WIDTH]); // see R12

	////////////////////////////////////////////////////////////////////////////////
	// Loop counter

	// Cleared and restarted by a run kick, held while stopped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count <= '0;
		end else if (run_kick) begin
			count <= '0; // see R5 R8
		end else if (run && count_tick) begin
			count <= count + 1'b1; // see R9
		end
	end

	assign overflow = run && !run_kick && count_tick && (count == COUNT_MAX);

	// Overflow action from the mode bits
	always_comb begin
		if (!watchdog_mode_select) begin
			action = ACT_INTERVAL; // see R1
		end else if (overflow_action_select) begin
			action = ACT_RESET; // see R3 R4
		end else begin
			action = ACT_NMI; // see R2
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Requests

	// One-cycle request pulses, registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			maskable_irq_req <= 1'b0;
			nmi_req <= 1'b0;
			sys_reset_req <= 1'b0;
		end else begin
			maskable_irq_req <= overflow && (action == ACT_INTERVAL); // see R1 R9
			nmi_req <= (overflow && (action == ACT_NMI)) || late_wd_set; // see R2 R15
			sys_reset_req <= overflow && (action == ACT_RESET); // see R3
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	interval_irq_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
		overflow |=> (maskable_irq_req == !$past(watchdog_mode_select)))
		else $error("interval request does not match overflow and mode");

	wd_nmi_a: assert property (@(posedge clk) disable iff (sys_rst) // see R2
		(overflow && watchdog_mode_select && !overflow_action_select)
		|=> nmi_req && !sys_reset_req && !maskable_irq_req)
		else $error("watchdog mode 1 overflow gave no non-maskable request");

	wd_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // see R3
		(overflow && watchdog_mode_select && overflow_action_select)
		|=> sys_reset_req && !maskable_irq_req)
		else $error("watchdog mode 2 overflow gave no reset");

	reset_cause_a: assert property (@(posedge clk) disable iff (sys_rst) // see R4
		sys_reset_req |-> $past(overflow) && $past(overflow_action_select)
		&& $past(watchdog_mode_select))
		else $error("reset request without mode 2 overflow");

	kick_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see R5
		run_kick |=> (count == '0) && run ##1 !(count > 8'h01))
		else $error("run kick did not clear counter");

	idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see R5
		!run |=> (count == '0) && !maskable_irq_req && !sys_reset_req)
		else $error("counter moved while not running");

	run_sticky_a: assert property (@(posedge clk) disable iff (sys_rst) // see R6
		run |=> run)
		else $error("run bit cleared without reset");

	mode_sticky_a: assert property (@(posedge clk) disable iff (sys_rst) // see R7
		(watchdog_mode_select || overflow_action_select) |=>
		(watchdog_mode_select >= $past(watchdog_mode_select))
		&& (overflow_action_select >= $past(overflow_action_select)))
		else $error("mode bit cleared without reset");

	reset_values_a: assert property (@(posedge clk) // see R10 R11
		sys_rst |=> (clock_select == 8'h00) && !run && !watchdog_mode_select
		&& !overflow_action_select)
		else $error("registers not cleared by reset");

	late_nmi_a: assert property (@(posedge clk) disable iff (sys_rst) // see R15
		(mode_run_wr && next_mode_run[WD_MODE_BIT] && !watchdog_mode_select
		&& timer_irq_pending_flag) |=> nmi_req)
		else $error("pending flag at watchdog entry gave no non-maskable request");

	half_rate_a: assert property (@(posedge clk) disable iff (sys_rst) // see R13
		(!osc_mode_bit && int_clk_en) ##1 !osc_mode_bit |-> !int_clk_en)
		else $error("internal clock not halved");

	frozen_a: assert property (@(posedge clk) disable iff (sys_rst) // see R19 R20
		(!count_allow && !run_kick) |=> $stable(count) && $stable(prescale))
		else $error("counter moved in stop standby or on subsystem clock");

	overflow_point_a: assert property (@(posedge clk) disable iff (sys_rst) // see R12
		(maskable_irq_req || nmi_req && !$past(late_wd_set) || sys_reset_req)
		|-> $past(count) == COUNT_MAX && (count == '0))
		else $error("overflow outside counter wrap");

endmodule // loop_watchdog_interval_timer

// *** tb/loop_watchdog_interval_timer_bench.sv ***
// Self-checking bench for the loop watchdog / interval timer.
// Assumes loop_wd_pkg is compiled first and clk runs at 50 MHz.
module loop_watchdog_interval_timer_bench
	import loop_wd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, wr_en, bit_wr, rd_en, osc_mode_bit; // Clock, reset, strobes
	logic halt_standby, stop_standby, sub_clock_active, timer_irq_pending_flag; // Levels
	logic [15:0] addr; // Register address
	logic [2:0] bit_idx; // Bit of a bit write
	logic [7:0] wdata, rdata; // Data both ways
	logic maskable_irq_req, nmi_req, sys_reset_req; // Overflow requests
	int n_errors, n_compared, cyc; // Counters
	int n_ev[3]; // Pulses seen: interval, non-maskable, reset
	int t_ev[3]; // Cycle of the last pulse of each kind
	logic [31:0] seed = 32'h9; // Xorshift state
	logic [7:0] cs_exp; // Expected clock-select readback

	loop_watchdog_interval_timer loop_watchdog_interval_timer_inst (.clk(clk),
		.sys_rst(sys_rst), .addr(addr), .wr_en(wr_en), .bit_wr(bit_wr), .bit_idx(bit_idx),
		.wdata(wdata), .rd_en(rd_en), .osc_mode_bit(osc_mode_bit),
		.halt_standby(halt_standby), .stop_standby(stop_standby),
		.sub_clock_active(sub_clock_active), .timer_irq_pending_flag(timer_irq_pending_flag),
		.rdata(rdata), .maskable_irq_req(maskable_irq_req), .nmi_req(nmi_req),
		.sys_reset_req(sys_reset_req));

	////////////////////////////////////////////////////////////////
	// Repeatable random numbers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Overflow period in clk cycles for a clock code and oscillation mode
	function automatic int period(input logic [2:0] code, input logic osc);
		return (code == 3'h7 ? 1 << 19 : 1 << (11 + code)) * (osc ? 1 : 2);
	endfunction

	// Clock at 20 ns
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Cycle count and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			n_errors++;
			end_of_test();
		end
	end

	// Pulses are one cycle wide, so the falling edge catches each once
	always @(negedge clk) begin
		if (maskable_irq_req === 1'h1) begin
			n_ev[0]++;
			t_ev[0] = cyc;
		end
		if (nmi_req === 1'h1) begin
			n_ev[1]++;
			t_ev[1] = cyc;
		end
		if (sys_reset_req === 1'h1) begin
			n_ev[2]++;
			t_ev[2] = cyc;
		end
	end

	////////////////////////////////////////////////////////////////
	// One comparison
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	// Register write, byte or single bit
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bw = 1'h0,
		input logic [2:0] bi = 3'h0);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		bit_wr <= bw;
		bit_idx <= bi;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask

	// Register read; data is settled just after the edge that takes it
	task automatic rd(input string what, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1 check(what, exp, rdata);
	endtask

	// Wait up to lim cycles for a pulse of kind k; t is -1 if none came
	task automatic wait_ev(input int k, input int lim, output int t);
		int n0;
		n0 = n_ev[k];
		t = -1;
		repeat (lim) begin
			@(posedge clk);
			if (n_ev[k] != n0) begin
				t = t_ev[k];
				break;
			end
		end
	endtask

	// Reset held for ten cycles
	task automatic do_reset();
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
	endtask

	// Interval mode: first and second period for one clock setting
	task automatic interval_run(input logic [2:0] code, input logic osc);
		int p, t0, t1, t2, others;
		logic [31:0] r;
		p = period(code, osc);
		r = rnd();
		others = n_ev[1] + n_ev[2];
		do_reset();
		rd("mode run reset", MODE_RUN_ADDR, MODE_RUN_RESET);
		rd("clock select reset", CLOCK_SELECT_ADDR, CLOCK_SELECT_RESET);
		@(posedge clk);
		osc_mode_bit <= osc;
		halt_standby <= r[8];
		wr(CLOCK_SELECT_ADDR, {r[7:3], code});
		cs_exp = {r[7:4], 1'h0, code};
		rd("clock select", CLOCK_SELECT_ADDR, cs_exp);
		wr(MODE_RUN_ADDR, 8'h80);
		t0 = cyc;
		wait_ev(0, p + 20, t1);
		check("first interval", 1, t1 - t0 <= p + 4 && t1 - t0 >= p - p / 200 - 2);
		wait_ev(0, p + 20, t2);
		check("interval period", p, t2 - t1);
		check("watchdog pulses", others, n_ev[1] + n_ev[2]);
	endtask

	// Verdict
	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int t, mi0, n1;
		{sys_rst, wr_en, bit_wr, rd_en, osc_mode_bit, halt_standby} = 6'h20;
		{stop_standby, sub_clock_active, timer_irq_pending_flag} = 3'h0;
		{addr, bit_idx, wdata} = 27'h0;
		do_reset();
		interval_run(3'h0, 1'h1);
		interval_run(3'h0, 1'h0);
		interval_run(3'h1, 1'(rnd() >> 31));
		interval_run(3'h2, 1'h1);
		// Run cannot be dropped by software; clock select ignores bit writes
		wr(MODE_RUN_ADDR, 8'h00);
		wr(MODE_RUN_ADDR, 8'h00, 1'h1, 3'h7);
		rd("run after clear", MODE_RUN_ADDR, 8'h80);
		wr(CLOCK_SELECT_ADDR, {7'h00, ~cs_exp[0]}, 1'h1, 3'h0);
		rd("clock select bit write", CLOCK_SELECT_ADDR, cs_exp);
		rd("unmapped read", 16'h1234, 8'h00);
		// Stop standby and subsystem clock freeze counting
		do_reset();
		osc_mode_bit <= 1'h1;
		wr(MODE_RUN_ADDR, 8'h80);
		stop_standby <= 1'h1;
		wait_ev(0, 2500, t);
		check("count in stop", 0, t >= 0);
		stop_standby <= 1'h0;
		sub_clock_active <= 1'h1;
		wait_ev(0, 2500, t);
		check("count on subclock", 0, t >= 0);
		sub_clock_active <= 1'h0;
		halt_standby <= 1'h1;
		wait_ev(0, 2100, t);
		check("count resumes", 1, t >= 0);
		// Watchdog mode 1 with kicks, then left to overflow
		do_reset();
		mi0 = n_ev[0];
		wr(MODE_RUN_ADDR, 8'h90);
		repeat (4) begin
			wait_ev(1, 1500, t);
			check("nmi despite kick", 0, t >= 0);
			wr(MODE_RUN_ADDR, 8'h01, 1'h1, 3'h7);
		end
		wait_ev(1, 2100, t);
		check("nmi on overflow", 1, t >= 0);
		check("interval in watchdog", mi0, n_ev[0]);
		wr(MODE_RUN_ADDR, 8'h00);
		rd("mode after clear", MODE_RUN_ADDR, 8'h90);
		// Watchdog mode 2
		do_reset();
		wr(MODE_RUN_ADDR, 8'h98);
		n1 = n_ev[1];
		wait_ev(2, 2100, t);
		check("reset on overflow", 1, t >= 0);
		check("nmi in mode 2", n1, n_ev[1]);
		wr(MODE_RUN_ADDR, 8'h00, 1'h1, 3'h3);
		rd("mode 2 after clear", MODE_RUN_ADDR, 8'h98);
		// Mode set while the pending flag is up
		do_reset();
		timer_irq_pending_flag <= 1'h1;
		wr(MODE_RUN_ADDR, 8'h10);
		wait_ev(1, 3, t);
		check("nmi on late mode set", 1, t >= 0);
		timer_irq_pending_flag <= 1'h0;
		end_of_test();
	end
endmodule // loop_watchdog_interval_timer_bench
